/* common/pram_defines.svh */
// Offsets, field positions and constants of the process RAM bridge
`ifndef PRAM_DEFINES_SVH
`define PRAM_DEFINES_SVH
// Device register offsets on the host link
`define OFS_FIFO_FIRST 16'h0020
`define OFS_FIFO_END 16'h003F
`define OFS_READBACK_CMD 16'h030C
`define OFS_STORE_ADDR_LEN 16'h0310
`define OFS_STORE_CMD 16'h0314
// Command register fields
`define BIT_STORE_BUSY 31
`define BIT_ABORT 30
`define POS_SPACE_CNT 8
`define BIT_SPACE_FLAG 0
// Address windows
`define PRAM_LO 16'h1000
`define PRAM_HI 16'h1FFF
`define DIRECT_TOP 16'h3000
// FIFO depth
`define FIFO_DEPTH 16
// Access error codes
`define ERR_NONE 2'h0
`define ERR_ODD_NO_BHE 2'h1
`define ERR_WR_EARLY 2'h2
`define ERR_RD_EARLY 2'h3
// Host controller APB offsets
`define HOFS_CTRL 8'h00
`define HOFS_ADDR 8'h04
`define HOFS_WDATA 8'h08
`define HOFS_STATUS 8'h0C
`define HOFS_RESULT 8'h10
`define HOFS_START_ADDR 8'h14
`define HOFS_START_LEN 8'h18
`endif

/* common/pram_pkg.sv */
// Types shared by both ends of the process RAM bridge
package pram_pkg;
   typedef enum logic [1:0] {
      SEL_INDIRECT = 2'h0,
      SEL_DIRECT8 = 2'h1,
      SEL_DIRECT16 = 2'h2
   } iface_sel_e;
   typedef enum logic [4:0] {
      L_IDLE = 5'h01,
      L_REG = 5'h02,
      L_CORE = 5'h04,
      L_DROP = 5'h08,
      L_DONE = 5'h10
   } link_state_e;
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_WRITE = 3'h1,
      OP_READ = 3'h2,
      OP_START = 3'h3,
      OP_PUSH = 3'h4,
      OP_ABORT_WR = 3'h5,
      OP_ABORT_RD = 3'h6
   } host_op_e;
   typedef enum logic [3:0] {
      H_IDLE = 4'h1,
      H_WAIT_HI = 4'h2,
      H_WAIT_LO = 4'h4,
      H_STEP = 4'h8
   } host_state_e;
endpackage

/* common/pram_link_if.sv */
// Host link between the controller and the bridge device
`timescale 1ns/1ps
interface pram_link_if;
   logic cs;
   logic wr;
   logic rd;
   logic fifo_direct;
   logic byte_high_enable_n;
   logic [15:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic busy;
   modport device(
      input cs, wr, rd, fifo_direct, byte_high_enable_n, addr, wdata,
      output rdata, busy
   );
   modport host(
      output cs, wr, rd, fifo_direct, byte_high_enable_n, addr, wdata,
      input rdata, busy
   );
endinterface

/* verilog/pram_bridge_device.sv */
// Process RAM write bridge and direct mapped access, device end
// Operation
// - Abort bit in command register cancels transfer
// - FIFO decoded at 20h plus seven aliases
// - Sixteen by 32-bit write FIFO
// - FIFO direct mode sends every write to FIFO
// - Host loads address/length, then sets busy
// - Host keeps transfer within 1000h to 1FFFh
// - Space flag shown; host pushes only with room
// - Count field gives writes allowed without polling
// - Busy self-clears after last word reaches core
// - Each FIFO word consumed as up to four lanes
// - Length and address fields track drain progress
// - First word lanes start at address bits
// - Last word lanes end at end offset
// - Single-word transfer uses start through end lanes
// - Direct map: CSRs 0-FFFh, RAM 1000h-2FFFh
// - Direct mode disables indirect access registers
// - Direct bus 8 or 16 bits, bytes too
// - Byte order always little endian
// - 8-bit mode address bits 1:0 pick byte
// - 16-bit mode decode by A0 and high enable
// - Flag odd-no-enable and early strobe release
// - Errors count, record cause, suppress or terminate
// - Core access: address, enables, request, acknowledge
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "pram_defines.svh"
module pram_bridge_device #(
   parameter int DEPTH = `FIFO_DEPTH
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Host link
   pram_link_if.device link,
   // Mode select
   input wire pram_pkg::iface_sel_e interface_select_field,
   // Core process data interface
   output logic core_req,
   output logic core_write,
   output logic [15:0] core_addr,
   output logic [3:0] core_be,
   output logic [31:0] core_wdata,
   input wire logic core_ack,
   input wire logic [31:0] core_rdata,
   // Access error status
   output logic [7:0] error_count,
   output logic [1:0] error_code
);
   import pram_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   link_state_e lst_reg;
   logic busy_reg, was_write_reg, mode8_reg, drain_own_reg;
   logic [1:0] lane_reg;
   logic [31:0] rdata_reg;
   logic [31:0] mem_reg [DEPTH];
   logic [AW-1:0] wp_reg, rp_reg;
   logic [AW:0] cnt_reg, space_cnt;
   logic store_busy_reg;
   logic [15:0] addr_reg, len_reg;
   logic [2:0] drain_n_reg;
   logic strobe, direct, fifo_hit, odd_no_bhe, in_window, start_acc;
   logic link_issue, reg_wr, push, pop, full, cmd_wr, al_wr;
   logic abort, start, drain_go, drain_ack, link_ack, early_end;
   logic [3:0] dm_be, dr_be;
   logic [31:0] dm_wdata, cmd_view, reg_view, rd_byte, rd_half;
   logic [1:0] lo;
   logic [16:0] endpos;
   logic [2:0] dr_n;

   assign link.busy = busy_reg;
   assign link.rdata = rdata_reg;

   // Access decode
   assign strobe = link.cs & (link.wr | link.rd);
   assign direct = interface_select_field != SEL_INDIRECT;
   assign fifo_hit = link.fifo_direct |
      (link.addr >= `OFS_FIFO_FIRST && link.addr <= `OFS_FIFO_END);
   assign odd_no_bhe = interface_select_field == SEL_DIRECT16 &
      link.addr[0] & link.byte_high_enable_n;
   assign in_window = link.addr < `DIRECT_TOP;
   assign start_acc = lst_reg == L_IDLE & strobe;
   assign link_issue = start_acc & direct & !odd_no_bhe & in_window;
   // indirect registers only outside direct mode
   assign reg_wr = start_acc & !direct & link.wr;
   assign full = cnt_reg == FULL;
   assign push = reg_wr & fifo_hit & !full;
   assign cmd_wr = reg_wr & !link.fifo_direct &
      link.addr == `OFS_STORE_CMD;
   assign al_wr = reg_wr & !link.fifo_direct &
      link.addr == `OFS_STORE_ADDR_LEN & !store_busy_reg;
   assign abort = cmd_wr & link.wdata[`BIT_ABORT];
   assign start = cmd_wr & !abort & link.wdata[`BIT_STORE_BUSY] &
      !store_busy_reg & len_reg != 16'h0000;
   assign drain_go = store_busy_reg & cnt_reg != '0 & !direct &
      !core_req & !link_issue & !abort;
   assign pop = drain_go;
   assign drain_ack = core_req & core_ack & drain_own_reg;
   assign link_ack = core_req & core_ack & !drain_own_reg;
   assign early_end = busy_reg & !strobe;
   assign space_cnt = FULL - cnt_reg;

   // Direct mode lanes
   always_comb begin
      if (interface_select_field == SEL_DIRECT8) begin
         dm_be = 4'h1 << link.addr[1:0];
         dm_wdata = {4{link.wdata[7:0]}};
      end else begin
         // word, low byte or high byte
         dm_be = (link.byte_high_enable_n ? 4'h1 :
            (link.addr[0] ? 4'h2 : 4'h3)) << {link.addr[1], 1'b0};
         dm_wdata = {2{link.wdata[15:0]}};
      end
   end

   assign rd_byte = core_rdata >> {lane_reg, 3'b000};
   assign rd_half = core_rdata >> {lane_reg[1], 4'h0};

   // Drain lane enables
   always_comb begin
      lo = addr_reg[1:0];
      endpos = {1'b0, len_reg} + {15'h0000, lo};
      if (endpos >= 17'h00004) begin
         // first word starts at address bits
         // full tail ends at lane 3
         dr_be = 4'hF << lo;
         dr_n = 3'h4 - {1'b0, lo};
      end else begin
         // last word ends at end offset
         dr_be = (4'hF << lo) & ~(4'hF << endpos[1:0]);
         dr_n = len_reg[2:0];
      end
   end

   // Register read view
   always_comb begin
      cmd_view = 32'h00000000;
      cmd_view[`BIT_STORE_BUSY] = store_busy_reg;
      cmd_view[`POS_SPACE_CNT +: AW + 1] = space_cnt;
      cmd_view[`BIT_SPACE_FLAG] = !full;
      reg_view = 32'h00000000;
      if (!link.fifo_direct && link.addr == `OFS_STORE_CMD) begin
         reg_view = cmd_view;
      end else if (!link.fifo_direct &&
         link.addr == `OFS_STORE_ADDR_LEN) begin
         reg_view = {len_reg, addr_reg};
      end
   end

   // FIFO storage
   always_ff @(posedge pclk) begin
      if (push) begin
         mem_reg[wp_reg] <= link.wdata;
      end
   end

   // FIFO pointers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else if (abort) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= rp_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   // Transfer address, length and busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= 16'h0000;
         len_reg <= 16'h0000;
         store_busy_reg <= 1'b0;
      end else begin
         if (al_wr) begin
            addr_reg <= link.wdata[15:0];
            len_reg <= link.wdata[31:16];
         end else if (drain_ack) begin
            addr_reg <= addr_reg + {13'h0000, drain_n_reg};
            len_reg <= len_reg - {13'h0000, drain_n_reg};
         end
         if (abort) begin
            store_busy_reg <= 1'b0;
         end else if (start) begin
            store_busy_reg <= 1'b1;
         end else if (drain_ack && len_reg == {13'h0000, drain_n_reg}) begin
            store_busy_reg <= 1'b0;
         end
      end
   end

   // Core request issue
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_req <= 1'b0;
         core_write <= 1'b0;
         core_addr <= 16'h0000;
         core_be <= 4'h0;
         core_wdata <= 32'h00000000;
         drain_own_reg <= 1'b0;
         drain_n_reg <= 3'h0;
      end else if (core_req) begin
         if (core_ack) begin
            core_req <= 1'b0;
         end
      end else if (link_issue) begin
         core_req <= 1'b1;
         core_write <= link.wr;
         core_addr <= {link.addr[15:2], 2'b00};
         core_be <= dm_be;
         core_wdata <= dm_wdata;
         drain_own_reg <= 1'b0;
      end else if (drain_go) begin
         core_req <= 1'b1;
         core_write <= 1'b1;
         core_addr <= {addr_reg[15:2], 2'b00};
         core_be <= dr_be;
         core_wdata <= mem_reg[rp_reg];
         drain_own_reg <= 1'b1;
         drain_n_reg <= dr_n;
      end
   end

   // Host link sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lst_reg <= L_IDLE;
         busy_reg <= 1'b0;
         was_write_reg <= 1'b0;
         mode8_reg <= 1'b0;
         lane_reg <= 2'h0;
         rdata_reg <= 32'h00000000;
      end else begin
         unique case (lst_reg)
            L_IDLE: if (strobe) begin
               busy_reg <= 1'b1;
               was_write_reg <= link.wr;
               mode8_reg <= interface_select_field == SEL_DIRECT8;
               lane_reg <= link.addr[1:0];
               rdata_reg <= direct ? 32'h00000000 : reg_view;
               lst_reg <= link_issue ? L_CORE : L_REG;
            end
            L_REG: begin
               busy_reg <= 1'b0;
               lst_reg <= strobe ? L_DONE : L_IDLE;
            end
            L_CORE: if (link_ack) begin
               busy_reg <= 1'b0;
               rdata_reg <= mode8_reg ? {24'h000000, rd_byte[7:0]} :
                  {16'h0000,
                  rd_half[15:8] & {8{core_be[1] | core_be[3]}},
                  rd_half[7:0] & {8{core_be[0] | core_be[2]}}};
               lst_reg <= strobe ? L_DONE : L_IDLE;
            end else if (!strobe) begin
               busy_reg <= 1'b0;
               lst_reg <= L_DROP;
            end
            L_DROP: if (link_ack) begin
               lst_reg <= L_IDLE;
            end
            L_DONE: if (!strobe) begin
               lst_reg <= L_IDLE;
            end
            default: begin
               busy_reg <= 1'b0;
               lst_reg <= L_IDLE;
            end
         endcase
      end
   end

   // Access error counter and cause
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_count <= 8'h00;
         error_code <= `ERR_NONE;
      end else if (start_acc && direct && odd_no_bhe) begin
         error_count <= error_count + 8'h01;
         error_code <= `ERR_ODD_NO_BHE;
      end else if (early_end) begin
         error_count <= error_count + 8'h01;
         error_code <= was_write_reg ? `ERR_WR_EARLY : `ERR_RD_EARLY;
      end
   end
endmodule

/* verilog/pram_bridge_host.sv */
// Host controller end: APB orders turned into link accesses
`timescale 1ns/1ps
`include "pram_defines.svh"
module pram_bridge_host (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device link
   pram_link_if.host link
);
   import pram_pkg::*;

   host_state_e hst_reg;
   host_op_e op_reg, op;
   logic step_reg, range_err_reg, cs_reg, wr_reg, rd_reg, fd_reg, bhe_n_reg;
   logic [15:0] tgt_addr_reg, start_addr_reg, start_len_reg, la_addr_reg;
   logic [31:0] tgt_wdata_reg, la_wdata_reg, result_reg;
   logic apb_wr, go, range_ok, nx_go, nx_wr;
   logic [15:0] nx_addr;
   logic [31:0] nx_wdata;
   logic [16:0] last_byte;

   assign link.cs = cs_reg;
   assign link.wr = wr_reg;
   assign link.rd = rd_reg;
   assign link.addr = la_addr_reg;
   assign link.wdata = la_wdata_reg;
   assign link.fifo_direct = fd_reg;
   assign link.byte_high_enable_n = bhe_n_reg;

   assign apb_wr = psel & penable & pready & pwrite;
   assign go = apb_wr & paddr == `HOFS_CTRL & hst_reg == H_IDLE;
   assign op = host_op_e'(pwdata[2:0]);
   // transfer must stay in process RAM
   assign last_byte = {1'b0, start_addr_reg} + {1'b0, start_len_reg} -
      17'h00001;
   assign range_ok = start_len_reg != 16'h0000 &&
      start_addr_reg >= `PRAM_LO && last_byte <= {1'b0, `PRAM_HI};

   // Next link access
   always_comb begin
      nx_go = 1'b0;
      nx_wr = 1'b1;
      nx_addr = tgt_addr_reg;
      nx_wdata = tgt_wdata_reg;
      if (hst_reg == H_IDLE && go) begin
         case (op)
            OP_WRITE: nx_go = 1'b1;
            OP_READ: begin
               nx_go = 1'b1;
               nx_wr = 1'b0;
            end
            OP_START: begin
               nx_go = range_ok;
               nx_addr = `OFS_STORE_ADDR_LEN;
               nx_wdata = {start_len_reg, start_addr_reg};
            end
            OP_PUSH: begin
               nx_go = 1'b1;
               nx_wr = 1'b0;
               nx_addr = `OFS_STORE_CMD;
            end
            OP_ABORT_WR: begin
               nx_go = 1'b1;
               nx_addr = `OFS_STORE_CMD;
               nx_wdata = 32'h00000001 << `BIT_ABORT;
            end
            OP_ABORT_RD: begin
               nx_go = 1'b1;
               nx_addr = `OFS_READBACK_CMD;
               nx_wdata = 32'h00000001 << `BIT_ABORT;
            end
            default: nx_go = 1'b0;
         endcase
      end else if (hst_reg == H_STEP && !step_reg) begin
         if (op_reg == OP_START) begin
            nx_go = 1'b1;
            nx_addr = `OFS_STORE_CMD;
            nx_wdata = 32'h00000001 << `BIT_STORE_BUSY;
         end else if (op_reg == OP_PUSH) begin
            // push only with room, else poll
            nx_go = 1'b1;
            nx_addr = result_reg[`BIT_SPACE_FLAG] ? `OFS_FIFO_FIRST :
               `OFS_STORE_CMD;
            nx_wr = result_reg[`BIT_SPACE_FLAG];
         end
      end
   end

   // Link access engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hst_reg <= H_IDLE;
         op_reg <= OP_NONE;
         step_reg <= 1'b0;
         range_err_reg <= 1'b0;
         cs_reg <= 1'b0;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         fd_reg <= 1'b0;
         bhe_n_reg <= 1'b1;
         la_addr_reg <= 16'h0000;
         la_wdata_reg <= 32'h00000000;
         result_reg <= 32'h00000000;
      end else begin
         unique case (hst_reg)
            H_IDLE: if (go) begin
               op_reg <= op;
               step_reg <= 1'b0;
               range_err_reg <= op == OP_START && !range_ok;
               fd_reg <= op == OP_WRITE && pwdata[4];
               bhe_n_reg <= pwdata[3];
            end
            H_WAIT_HI: if (link.busy) begin
               hst_reg <= H_WAIT_LO;
            end
            H_WAIT_LO: if (!link.busy) begin
               result_reg <= link.rdata;
               cs_reg <= 1'b0;
               wr_reg <= 1'b0;
               rd_reg <= 1'b0;
               hst_reg <= H_STEP;
            end
            H_STEP: begin
               if (nx_go) begin
                  step_reg <= op_reg != OP_PUSH ||
                     result_reg[`BIT_SPACE_FLAG];
               end else begin
                  hst_reg <= H_IDLE;
               end
            end
         endcase
         if (nx_go) begin
            cs_reg <= 1'b1;
            wr_reg <= nx_wr;
            rd_reg <= !nx_wr;
            la_addr_reg <= nx_addr;
            la_wdata_reg <= nx_wdata;
            hst_reg <= H_WAIT_HI;
         end
      end
   end

   // APB registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgt_addr_reg <= 16'h0000;
         tgt_wdata_reg <= 32'h00000000;
         start_addr_reg <= 16'h0000;
         start_len_reg <= 16'h0000;
      end else if (apb_wr) begin
         case (paddr)
            `HOFS_ADDR: tgt_addr_reg <= pwdata[15:0];
            `HOFS_WDATA: tgt_wdata_reg <= pwdata;
            `HOFS_START_ADDR: start_addr_reg <= pwdata[15:0];
            `HOFS_START_LEN: start_len_reg <= pwdata[15:0];
            default: tgt_addr_reg <= tgt_addr_reg;
         endcase
      end
   end

   // APB handshake and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               `HOFS_ADDR: prdata <= {16'h0000, tgt_addr_reg};
               `HOFS_WDATA: prdata <= tgt_wdata_reg;
               `HOFS_STATUS: prdata <= {30'h00000000, range_err_reg,
                  hst_reg != H_IDLE};
               `HOFS_RESULT: prdata <= result_reg;
               `HOFS_START_ADDR: prdata <= {16'h0000, start_addr_reg};
               `HOFS_START_LEN: prdata <= {16'h0000, start_len_reg};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

/* bench/pram_bridge_asserts.sv */
// Assertions on the link and core side of the bridge
`timescale 1ns/1ps
module pram_bridge_asserts (
   // Clock, reset and link
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs,
   input wire logic wr,
   input wire logic rd,
   input wire logic byte_high_enable_n,
   input wire logic [15:0] addr,
   input wire logic busy,
   // Device side
   input wire pram_pkg::iface_sel_e interface_select_field,
   input wire logic core_req,
   input wire logic core_ack,
   input wire logic [15:0] core_addr,
   input wire logic [3:0] core_be,
   input wire logic [7:0] error_count,
   input wire logic [1:0] error_code
);
   import pram_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_pend;
      core_req && !core_ack;
   endsequence
   sequence s_held;
      core_req && $stable(core_addr) && $stable(core_be);
   endsequence
   a_req_held: assert property (s_pend |=> s_held)
      else $error("core request dropped early");
   a_busy_cause: assert property ($rose(busy) |->
      $past(cs && (wr || rd))) else $error("busy without request");
   a_word_align: assert property (core_req |-> core_addr[1:0] == 2'h0
      && core_be != 4'h0) else $error("core access misaligned");
   a_direct_map: assert property (core_req &&
      interface_select_field != SEL_INDIRECT |->
      core_addr == {addr[15:2], 2'h0} && addr < 16'h3000)
      else $error("direct address wrong");
   a_byte_lane: assert property (core_req && interface_select_field ==
      SEL_DIRECT8 |-> core_be == 4'h1 << addr[1:0])
      else $error("byte lane wrong");
   a_odd_skip: assert property (cs && wr && !busy && addr[0] &&
      interface_select_field == SEL_DIRECT16 && byte_high_enable_n |=>
      !core_req [*3]) else $error("invalid access reached core");
   a_busy_end: assert property (core_ack && busy &&
      interface_select_field != SEL_INDIRECT |=> ##[0:1] !busy)
      else $error("busy stuck after ack");
   a_err_step: assert property ($changed(error_count) |->
      error_count == $past(error_count) + 8'h1) else $error("count jump");
   a_err_cause: assert property ($changed(error_count) |->
      error_code != 2'h0) else $error("error without cause");
endmodule

/* bench/test_process_ram_host_access_bridge.sv */
// Bench for host controller and device joined by the link
`timescale 1ns/1ps
`include "pram_defines.svh"
module test_process_ram_host_access_bridge;
   import pram_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, cwd;
   logic [31:0] crd = 32'h0;
   logic pready, creq, cwr, go;
   logic ack = 1'b0;
   logic ack_en = 1'b1;
   logic [15:0] cad;
   logic [3:0] cbe;
   logic [7:0] ecnt;
   logic [1:0] ecode;
   iface_sel_e sel = SEL_INDIRECT;
   int errors = 0;
   int cmp_count = 0;
   logic [15:0] al[$];
   logic [3:0] bl[$];
   logic [31:0] dl[$];
   pram_link_if link();
   always #2 pclk = ~pclk;
   pram_bridge_host pram_bridge_host_i (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
      .link(link.host));
   pram_bridge_device pram_bridge_device_i (.pclk(pclk), .presetn(presetn),
      .link(link.device), .interface_select_field(sel), .core_req(creq),
      .core_write(cwr), .core_addr(cad), .core_be(cbe), .core_wdata(cwd),
      .core_ack(ack), .core_rdata(crd), .error_count(ecnt),
      .error_code(ecode));
   pram_bridge_asserts pram_bridge_asserts_i (.pclk(pclk), .presetn(presetn),
      .cs(link.cs), .wr(link.wr), .rd(link.rd), .addr(link.addr),
      .byte_high_enable_n(link.byte_high_enable_n), .busy(link.busy),
      .interface_select_field(sel), .core_req(creq), .core_ack(ack),
      .core_addr(cad), .core_be(cbe), .error_count(ecnt),
      .error_code(ecode));
   // Core answers after a random wait and logs writes
   always @(posedge pclk) begin
      go = creq && !ack && ack_en && $urandom_range(1) == 1;
      ack <= go;
      if (go) begin
         crd <= {cad, ~cad};
         if (cwr) begin
            al.push_back(cad);
            bl.push_back(cbe);
            dl.push_back(cwd);
         end
      end
   end
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         errors++;
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic op(input logic [2:0] o, input logic [1:0] f,
      input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      apb(1'b1, `HOFS_ADDR, {16'h0, a}, q);
      apb(1'b1, `HOFS_WDATA, d, q);
      apb(1'b1, `HOFS_CTRL, {27'h0, f, o}, q);
      do begin
         apb(1'b0, `HOFS_STATUS, 32'h0, q);
         n++;
      end while (q[0] !== 1'b0 && n < 100);
      if (q[0] !== 1'b0)
         errors++;
      apb(1'b0, `HOFS_RESULT, 32'h0, q);
   endtask
   function automatic logic [3:0] exp_be(int s, int l, int wb);
      for (int i = 0; i < 4; i++)
         exp_be[i] = wb + i >= s && wb + i < s + l;
   endfunction
   function automatic logic [31:0] lanes(logic [3:0] be, logic w16,
      logic [31:0] d);
      for (int i = 0; i < 4; i++)
         lanes[8*i +: 8] = !be[i] ? 8'h00 : (w16 && i % 2) ? d[15:8] : d[7:0];
   endfunction
   task automatic xfer(input int s, input int l, input logic fd);
      logic [31:0] q;
      logic [31:0] w[$];
      int n;
      int t;
      n = ((s & 3) + l + 3) / 4;
      t = 0;
      al.delete();
      bl.delete();
      dl.delete();
      apb(1'b1, `HOFS_START_ADDR, s, q);
      apb(1'b1, `HOFS_START_LEN, l, q);
      op(3'h3, 2'h0, 16'h0, 32'h0, q);
      op(3'h2, 2'h0, `OFS_STORE_CMD, 32'h0, q);
      chk(q & 32'h80001F01, 32'h80001001);
      for (int k = 0; k < n; k++) begin
         w.push_back($urandom);
         if (k == 0)
            op(3'h4, 2'h0, 16'h0, w[k], q);
         else
            op(3'h1, {fd, 1'b0}, fd ? 16'($urandom) : 16'(32 + 4 * (k % 8)),
               w[k], q);
      end
      do begin
         op(3'h2, 2'h0, `OFS_STORE_CMD, 32'h0, q);
         t++;
      end while (q[31] !== 1'b0 && t < 40);
      chk(q[31], 1'b0);
      op(3'h2, 2'h0, `OFS_STORE_ADDR_LEN, 32'h0, q);
      chk(q, 32'(s + l));
      chk(al.size(), n);
      foreach (al[k]) begin
         chk(al[k], (s & ~3) + 4 * k);
         chk(bl[k], exp_be(s, l, (s & ~3) + 4 * k));
         chk(dl[k], w[k]);
      end
   endtask
   initial begin
      #400000;
      errors++;
      end_sim();
   end
   initial begin
      int j;
      logic [15:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic [7:0] e;
      logic [3:0] eb;
      logic [31:0] m;
      void'($urandom(92580));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      ack_en <= 1'b0;
      apb(1'b1, `HOFS_START_ADDR, 32'h1FFE, q);
      apb(1'b1, `HOFS_START_LEN, 32'h4, q);
      op(3'h3, 2'h0, 16'h0, 32'h0, q);
      apb(1'b0, `HOFS_STATUS, 32'h0, q);
      chk(q[1], 1'b1);
      apb(1'b1, `HOFS_START_ADDR, 32'h1000, q);
      apb(1'b1, `HOFS_START_LEN, 32'd16, q);
      op(3'h3, 2'h0, 16'h0, 32'h0, q);
      repeat (2) op(3'h1, 2'h0, 16'h20, $urandom, q);
      op(3'h5, 2'h0, 16'h0, 32'h0, q);
      op(3'h2, 2'h0, `OFS_STORE_CMD, 32'h0, q);
      chk(q & 32'h80001F01, 32'h00001001);
      op(3'h2, 2'h0, `OFS_STORE_ADDR_LEN, 32'h0, q);
      chk(q, 32'h00101000);
      ack_en <= 1'b1;
      while (creq)
         @(posedge pclk);
      for (int k = 0; k < 14; k++)
         xfer(k < 4 ? 32'h1000 + k : 32'h1000 + $urandom_range(32'hFE0),
            k < 4 ? 4 - k : $urandom_range(28, 1), k % 3 == 2);
      for (int k = 0; k < 24; k++) begin
         j = k % 4;
         sel <= k < 8 ? SEL_DIRECT8 : SEL_DIRECT16;
         a = 16'($urandom_range(32'h2FFF));
         if (k >= 8)
            a[0] = j[1];
         d = $urandom;
         e = ecnt;
         al.delete();
         bl.delete();
         dl.delete();
         op(3'h1, {1'b0, j[0]}, a, d, q);
         eb = (k >= 8 && j == 0) ? 4'h3 << a[1:0] : 4'h1 << a[1:0];
         if (k >= 8 && j == 3) begin
            chk(al.size(), 0);
            chk(ecnt, e + 8'h1);
            chk(ecode, `ERR_ODD_NO_BHE);
         end else begin
            chk(bl[0], eb);
            chk(dl[0] & lanes(eb, 1'b1, '1), lanes(eb, k >= 8, d));
            op(3'h2, {1'b0, j[0]}, a, 32'h0, q);
            m = k < 8 ? 32'hFF : {16'h0, {8{j != 1}}, {8{j != 2}}};
            chk(q, m & ({a[15:2], 2'h0, ~a[15:2], 2'h3} >>
               (k < 8 ? 8 * a[1:0] : 16 * a[1])));
         end
      end
      end_sim();
   end
endmodule
